// *** shared/occr_pkg.sv ***
// Package for the output channel configuration register bank
// Contract
// - Channel powerdown bit disables that channel's mux/divider
// - Pair bits disable channels 0/1 or 2/3
// - Bit 6 powers down CMOS channel
// - Format field decodes off/diff/HCSL/CMOS
// - Mode-one picks tail current in differential
// - Mode-one controls positive pin in CMOS
// - Mode-two picks HCSL load or negative pin
// - Shared divider ratio is field plus one
package occr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] OCCR_IDX_CHANNEL_POWERDOWN   = 8'h1E;
  localparam logic [7:0] OCCR_IDX_CTL0   = 8'h1F;
  localparam logic [7:0] OCCR_IDX_CTL1   = 8'h20;
  localparam logic [7:0] OCCR_IDX_DIV01  = 8'h21;
  localparam logic [7:0] OCCR_IDX_CTL2   = 8'h22;
  localparam logic [7:0] OCCR_IDX_CTL3   = 8'h23;
  localparam logic [7:0] OCCR_IDX_NVCTL  = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OCCR_BIT_CMOS_OFF  = 6;
  localparam int OCCR_BIT_CH7_OFF   = 5;
  localparam int OCCR_BIT_CH6_OFF   = 4;
  localparam int OCCR_BIT_CH5_OFF   = 3;
  localparam int OCCR_BIT_CH4_OFF   = 2;
  localparam int OCCR_BIT_PAIR23    = 1;
  localparam int OCCR_BIT_PAIR01    = 0;
  localparam int OCCR_FMT_HI        = 6;
  localparam int OCCR_FMT_LO        = 5;
  localparam int OCCR_M1_HI         = 4;
  localparam int OCCR_M1_LO         = 3;
  localparam int OCCR_M2_HI         = 2;
  localparam int OCCR_M2_LO         = 1;
  localparam int OCCR_BIT_RSV7      = 7;
  localparam int OCCR_BIT_NV_LOAD   = 0;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OCCR_MASK_CHANNEL_POWERDOWN  = 8'h7F;
  localparam logic [7:0] OCCR_MASK_CTLR  = 8'hFE;
  localparam logic [7:0] OCCR_MASK_CTL   = 8'h7E;
  localparam logic [7:0] OCCR_MASK_DIV   = 8'hFF;
  localparam logic [7:0] OCCR_RST_CHANNEL_POWERDOWN   = 8'h00;
  localparam logic [7:0] OCCR_RST_CTLR   = 8'hB0;
  localparam logic [7:0] OCCR_RST_CTL    = 8'h30;
  localparam logic [7:0] OCCR_RST_DIV01  = 8'h01;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OCCR_FMT_OFF  = 2'h0,
    OCCR_FMT_DIFF = 2'h1,
    OCCR_FMT_HCSL = 2'h2,
    OCCR_FMT_CMOS = 2'h3
  } occr_fmt_t;

  localparam logic [1:0] OCCR_PIN_TRI  = 2'h0;
  localparam logic [1:0] OCCR_PIN_LOW  = 2'h1;
  localparam logic [1:0] OCCR_PIN_INV  = 2'h2;
  localparam logic [1:0] OCCR_PIN_TRUE = 2'h3;

  localparam logic [4:0] OCCR_MA_4  = 5'h04;
  localparam logic [4:0] OCCR_MA_6  = 5'h06;
  localparam logic [4:0] OCCR_MA_8  = 5'h08;
  localparam logic [4:0] OCCR_MA_16 = 5'h10;

endpackage

// *** design/occr_chan_decode.sv ***
// Per-channel driver decode for one output control register
`timescale 1ns/1ps
module occr_chan_decode
  import occr_pkg::*;
(
  input  wire logic [7:0] ctl_i,
  output logic      [1:0] fmt_o,
  output logic      [4:0] tail_ma_o,
  output logic      [1:0] hcsl_load_o,
  output logic            drv_en_o,
  output logic      [1:0] pos_pin_o,
  output logic      [1:0] neg_pin_o
);

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic [1:0] m1;
  logic [1:0] m2;
  logic       is_cmos;
  logic       is_diff;
  assign fmt_o    = ctl_i[OCCR_FMT_HI:OCCR_FMT_LO];
  assign m1       = ctl_i[OCCR_M1_HI:OCCR_M1_LO];
  assign m2       = ctl_i[OCCR_M2_HI:OCCR_M2_LO];
  assign drv_en_o = (fmt_o != OCCR_FMT_OFF);
  assign is_cmos  = (fmt_o == OCCR_FMT_CMOS);
  assign is_diff  = (fmt_o == OCCR_FMT_DIFF) || (fmt_o == OCCR_FMT_HCSL);

  // Tail current; code 3 depends on HCSL versus LVPECL
  always_comb begin
    tail_ma_o = 5'h00;
    if (is_diff) begin
      unique case (m1)
        2'h0: tail_ma_o = OCCR_MA_4;
        2'h1: tail_ma_o = OCCR_MA_6;
        2'h2: tail_ma_o = OCCR_MA_8;
        2'h3: tail_ma_o = (fmt_o == OCCR_FMT_HCSL) ? OCCR_MA_16 : OCCR_MA_8;
      endcase
    end
  end

  // Load control means something in both differential formats, pin controls only in CMOS
  assign hcsl_load_o = is_diff ? m2 : OCCR_PIN_TRI;
  assign pos_pin_o   = is_cmos ? m1 : OCCR_PIN_TRI;
  assign neg_pin_o   = is_cmos ? m2 : OCCR_PIN_TRI;

endmodule // occr_chan_decode

// *** design/occr_regs.sv ***
// Output channel configuration register bank with classic Wishbone slave
`timescale 1ns/1ps
module occr_regs
  import occr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Nonvolatile image, presented with a one-cycle load pulse
  input  wire logic        nv_load_i,
  input  wire logic [7:0]  nv_channel_powerdown_i,
  input  wire logic [7:0]  nv_ctl0_i,
  input  wire logic [7:0]  nv_ctl1_i,
  input  wire logic [7:0]  nv_div01_i,
  input  wire logic [7:0]  nv_ctl2_i,
  input  wire logic [7:0]  nv_ctl3_i,
  // Gating of channel mux and divider
  output logic             cmos_channel_off_o,
  output logic             chan7_off_o,
  output logic             chan6_off_o,
  output logic             chan5_off_o,
  output logic             chan4_off_o,
  output logic      [3:0]  chan_mux_off_o,
  output logic             div01_off_o,
  output logic             div23_off_o,
  output logic      [8:0]  div01_ratio_o,
  // Per channel driver settings, channel n in slice n
  output logic      [7:0]  fmt_o,
  output logic      [3:0]  drv_en_o,
  output logic      [19:0] tail_ma_o,
  output logic      [7:0]  hcsl_load_o,
  output logic      [7:0]  pos_pin_o,
  output logic      [7:0]  neg_pin_o
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] channel_powerdown;
  logic [7:0] output0_control;
  logic [7:0] output1_control;
  logic [7:0] output01_divider;
  logic [7:0] output2_control;
  logic [7:0] output3_control;
  logic       nv_reloaded;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Index is the word address; low two bits must be zero
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[31:2] == {22'h0, idx});
  endfunction

  // Masked byte-lane merge; reserved bits stay zero
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wr_v,
                                       input logic [7:0] mask);
    merge = (wr_v & mask) | (old_v & ~mask);
  endfunction

  logic       req;
  logic       lane0;
  logic       hit_channel_powerdown;
  logic       hit_ctl0;
  logic       hit_ctl1;
  logic       hit_div;
  logic       hit_ctl2;
  logic       hit_ctl3;
  logic       hit_nv;
  logic       hit_any;
  logic       wr_en;
  logic       wr_ok;
  logic [7:0] wdat;
  logic [7:0] rdat;

  // Answer one cycle after the request; ack drops the next cycle
  assign req      = cyc_i && stb_i && !ack_o && !err_o;
  assign lane0    = sel_i[0];
  assign wdat     = dat_i[7:0];
  assign hit_channel_powerdown = hit(adr_i, OCCR_IDX_CHANNEL_POWERDOWN);
  assign hit_ctl0 = hit(adr_i, OCCR_IDX_CTL0);
  assign hit_ctl1 = hit(adr_i, OCCR_IDX_CTL1);
  assign hit_div  = hit(adr_i, OCCR_IDX_DIV01);
  assign hit_ctl2 = hit(adr_i, OCCR_IDX_CTL2);
  assign hit_ctl3 = hit(adr_i, OCCR_IDX_CTL3);
  assign hit_nv   = hit(adr_i, OCCR_IDX_NVCTL);
  assign hit_any  = hit_channel_powerdown | hit_ctl0 | hit_ctl1 | hit_div | hit_ctl2 | hit_ctl3 | hit_nv;
  assign wr_en    = req && we_i && lane0;
  // Write lands on the same edge that raises ack, so the master sees it at its ack edge
  assign wr_ok    = wr_en && hit_any;

  // Read mux; unmapped words read zero but answer with err
  assign rdat = hit_channel_powerdown ? channel_powerdown :
                hit_ctl0 ? output0_control   :
                hit_ctl1 ? output1_control   :
                hit_div  ? output01_divider  :
                hit_ctl2 ? output2_control   :
                hit_ctl3 ? output3_control   :
                hit_nv   ? {7'h00, nv_reloaded} : 8'h00;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && hit_any;
      err_o <= req && !hit_any;
      dat_o <= req ? {24'h000000, rdat} : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // Register file; a nonvolatile reload outranks a bus write
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      channel_powerdown <= OCCR_RST_CHANNEL_POWERDOWN;
      output0_control   <= OCCR_RST_CTLR;
      output1_control   <= OCCR_RST_CTL;
      output01_divider  <= OCCR_RST_DIV01;
      output2_control   <= OCCR_RST_CTLR;
      output3_control   <= OCCR_RST_CTL;
    end else if (nv_load_i) begin
      channel_powerdown <= nv_channel_powerdown_i & OCCR_MASK_CHANNEL_POWERDOWN;
      output0_control   <= nv_ctl0_i & OCCR_MASK_CTLR;
      output1_control   <= nv_ctl1_i & OCCR_MASK_CTL;
      output01_divider  <= nv_div01_i;
      output2_control   <= nv_ctl2_i & OCCR_MASK_CTLR;
      output3_control   <= nv_ctl3_i & OCCR_MASK_CTL;
    end else if (wr_ok) begin
      if (hit_channel_powerdown) begin
        channel_powerdown <= merge(channel_powerdown, wdat, OCCR_MASK_CHANNEL_POWERDOWN);
      end
      if (hit_ctl0) begin
        output0_control <= merge(output0_control, wdat, OCCR_MASK_CTLR);
      end
      if (hit_ctl1) begin
        output1_control <= merge(output1_control, wdat, OCCR_MASK_CTL);
      end
      if (hit_div) begin
        output01_divider <= merge(output01_divider, wdat, OCCR_MASK_DIV);
      end
      if (hit_ctl2) begin
        output2_control <= merge(output2_control, wdat, OCCR_MASK_CTLR);
      end
      if (hit_ctl3) begin
        output3_control <= merge(output3_control, wdat, OCCR_MASK_CTL);
      end
    end
  end

  // Sticky reload flag: a reload in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_reloaded <= 1'b0;
    end else if (nv_load_i) begin
      nv_reloaded <= 1'b1;
    end else if (wr_ok && hit_nv && wdat[OCCR_BIT_NV_LOAD]) begin
      nv_reloaded <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Powerdown decode; driver buffers are not touched by these
  // ------------------------------------------------------------
  assign cmos_channel_off_o = channel_powerdown[OCCR_BIT_CMOS_OFF];
  assign chan7_off_o        = channel_powerdown[OCCR_BIT_CH7_OFF];
  assign chan6_off_o        = channel_powerdown[OCCR_BIT_CH6_OFF];
  assign chan5_off_o        = channel_powerdown[OCCR_BIT_CH5_OFF];
  assign chan4_off_o        = channel_powerdown[OCCR_BIT_CH4_OFF];
  assign div01_off_o        = channel_powerdown[OCCR_BIT_PAIR01];
  assign div23_off_o        = channel_powerdown[OCCR_BIT_PAIR23];
  assign chan_mux_off_o     = {{2{channel_powerdown[OCCR_BIT_PAIR23]}},
                               {2{channel_powerdown[OCCR_BIT_PAIR01]}}};

  // Ratio is field plus one, 1 to 256
  assign div01_ratio_o = {1'b0, output01_divider} + 9'h001;

  // ------------------------------------------------------------
  // Driver decode; software shuts a path fully with format 0
  // ------------------------------------------------------------
  logic [7:0] ctl_arr [4];
  assign ctl_arr[0] = output0_control;
  assign ctl_arr[1] = output1_control;
  assign ctl_arr[2] = output2_control;
  assign ctl_arr[3] = output3_control;

  for (genvar c = 0; c < 4; c++) begin : g_chan
    occr_chan_decode u_dec (
      .ctl_i       (ctl_arr[c]),
      .fmt_o       (fmt_o[2*c +: 2]),
      .tail_ma_o   (tail_ma_o[5*c +: 5]),
      .hcsl_load_o (hcsl_load_o[2*c +: 2]),
      .drv_en_o    (drv_en_o[c]),
      .pos_pin_o   (pos_pin_o[2*c +: 2]),
      .neg_pin_o   (neg_pin_o[2*c +: 2])
    );
  end

endmodule // occr_regs

// *** bench/occr_regs_checker.sv ***
// Assertion checker for the output channel configuration register bank
`timescale 1ns/1ps
module occr_regs_checker
  import occr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        nv_load_i,
  input wire logic        cmos_channel_off_o,
  input wire logic        chan7_off_o,
  input wire logic [3:0]  chan_mux_off_o,
  input wire logic        div01_off_o,
  input wire logic        div23_off_o,
  input wire logic [8:0]  div01_ratio_o,
  input wire logic [7:0]  fmt_o,
  input wire logic [3:0]  drv_en_o,
  input wire logic [19:0] tail_ma_o,
  input wire logic [7:0]  pos_pin_o,
  input wire logic [7:0]  neg_pin_o
);
  // ----------------------------------------
  // Handshake and register effects
  // ----------------------------------------
  logic [31:0] dat_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write data of the taken edge, kept for the cycle after
  always_ff @(posedge clk_i) begin
    dat_q <= dat_i;
  end
  // A reload in the same cycle wins, so such requests are left out
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o && !nv_load_i;
  endsequence
  sequence s_wr(logic [31:0] a);
    s_take ##0 (we_i && sel_i[0] && adr_i == a);
  endsequence
  a_one_answer: assert property (s_take |=> (ack_o != err_o) ##1 !(ack_o || err_o))
    else $error("bus answer is not one pulse");
  a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_channel_powerdown_write: assert property (s_wr(32'h78) |=>
    {cmos_channel_off_o, chan7_off_o} == dat_q[6:5])
    else $error("powerdown bits not applied");
  a_pair_gates: assert property (chan_mux_off_o == {{2{div23_off_o}}, {2{div01_off_o}}})
    else $error("pair gating mismatch");
  a_div_ratio: assert property (s_wr(32'h84) |=> div01_ratio_o == 9'h001 + dat_q[7:0])
    else $error("divider ratio wrong");
  a_fmt_write: assert property (s_wr(32'h7C) |=>
    fmt_o[1:0] == dat_q[6:5] && drv_en_o[0] == |dat_q[6:5])
    else $error("format select not applied");
  a_cmos_pins: assert property (fmt_o[1:0] != 2'h3 |->
    {pos_pin_o[1:0], neg_pin_o[1:0]} == 4'h0)
    else $error("pin mode outside CMOS format");
  a_tail_off: assert property (fmt_o[7:6] inside {2'h0, 2'h3} |->
    tail_ma_o[19:15] == 5'h00)
    else $error("tail current outside differential");
  a_reset_vals: assert property ($fell(rst_i) |-> fmt_o == 8'h55 && div01_ratio_o == 9'h002)
    else $error("reset values wrong");
endmodule // occr_regs_checker

bind occr_regs occr_regs_checker u_occr_regs_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .nv_load_i(nv_load_i), .cmos_channel_off_o(cmos_channel_off_o),
  .chan7_off_o(chan7_off_o), .chan_mux_off_o(chan_mux_off_o), .div01_off_o(div01_off_o),
  .div23_off_o(div23_off_o), .div01_ratio_o(div01_ratio_o), .fmt_o(fmt_o),
  .drv_en_o(drv_en_o), .tail_ma_o(tail_ma_o), .pos_pin_o(pos_pin_o), .neg_pin_o(neg_pin_o)
);

// *** bench/occr_regs_tb.sv ***
// Self-checking testbench for the output channel configuration register bank
`timescale 1ns/1ps
module occr_regs_tb
  import occr_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, nv_load_i;
  logic        cmos_channel_off_o, chan7_off_o, chan6_off_o, chan5_off_o, chan4_off_o;
  logic        div01_off_o, div23_off_o;
  logic [31:0] adr_i, dat_i, dat_o;
  logic [3:0]  sel_i, chan_mux_off_o, drv_en_o;
  logic [7:0]  nv_channel_powerdown_i, nv_ctl0_i, nv_ctl1_i, nv_div01_i, nv_ctl2_i, nv_ctl3_i;
  logic [7:0]  fmt_o, hcsl_load_o, pos_pin_o, neg_pin_o;
  logic [8:0]  div01_ratio_o;
  logic [19:0] tail_ma_o;
  int          err_total, num_checks;

  occr_regs u_occr_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .nv_load_i(nv_load_i), .nv_channel_powerdown_i(nv_channel_powerdown_i), .nv_ctl0_i(nv_ctl0_i),
    .nv_ctl1_i(nv_ctl1_i), .nv_div01_i(nv_div01_i), .nv_ctl2_i(nv_ctl2_i),
    .nv_ctl3_i(nv_ctl3_i), .cmos_channel_off_o(cmos_channel_off_o),
    .chan7_off_o(chan7_off_o), .chan6_off_o(chan6_off_o), .chan5_off_o(chan5_off_o),
    .chan4_off_o(chan4_off_o), .chan_mux_off_o(chan_mux_off_o),
    .div01_off_o(div01_off_o), .div23_off_o(div23_off_o),
    .div01_ratio_o(div01_ratio_o), .fmt_o(fmt_o), .drv_en_o(drv_en_o),
    .tail_ma_o(tail_ma_o), .hcsl_load_o(hcsl_load_o), .pos_pin_o(pos_pin_o),
    .neg_pin_o(neg_pin_o)
  );

  // ----------------------------------------
  // Clock, checks and bus cycles
  // ----------------------------------------
  always #2 clk_i = ~clk_i;

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // One classic cycle; the wait is open-ended, only the watchdog ends it
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q, output logic e);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
    adr_i <= {24'h0, a}; dat_i <= {24'h0, d}; sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q; logic e;
    wb(1'b1, a, d, 4'h1, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [7:0] q; logic e;
    wb(1'b0, a, 8'h00, 4'hF, q, e);
    chk(e === xe && (xe || q === x), "read back mismatch");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  logic [7:0] adr_t [6] = '{8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C};
  logic [7:0] rst_t [6] = '{8'h00, 8'hB0, 8'h30, 8'h01, 8'hB0, 8'h30};
  logic [7:0] nv_t  [6] = '{8'h7F, 8'hFE, 8'h7E, 8'hFF, 8'hFE, 8'h7E};

  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd(adr_t[i], rst_t[i], 1'b0);
    chk(fmt_o === 8'h55 && div01_ratio_o === 9'h002, "reset outputs");
  endtask

  task automatic t_channel_powerdown;
    logic [6:0] v;
    for (int i = 0; i < 7; i++) begin
      v = 7'h01 << i;
      wr(8'h78, {1'b0, v});
      chk({cmos_channel_off_o, chan7_off_o, chan6_off_o, chan5_off_o, chan4_off_o,
           div23_off_o, div01_off_o} === v, "powerdown gating");
      chk(chan_mux_off_o === {{2{v[1]}}, {2{v[0]}}}, "pair mux gating");
      chk(drv_en_o === 4'hF, "powerdown turned a driver off");
    end
    wr(8'h80, 8'h00);
    chk(drv_en_o[1] === 1'b0 && fmt_o[3:2] === 2'h0, "format zero shutdown");
    wr(8'h78, 8'hFF);
    rd(8'h78, 8'h7F, 1'b0);
  endtask

  // Every format and mode-one code, mode two offset, on each channel
  task automatic t_fmt;
    logic [1:0] f, m, n; logic [4:0] t; logic d;
    for (int k = 0; k < 4; k++) for (int c = 0; c < 16; c++) begin
      f = c[3:2]; m = c[1:0]; n = m ^ 2'h1;
      wr(adr_t[k + (k > 1 ? 2 : 1)], {1'b0, f, m, n, 1'b0});
      d = (f == 2'h1 || f == 2'h2);
      t = m == 2'h0 ? 5'h04 : m == 2'h1 ? 5'h06 : (m == 2'h3 && f == 2'h2) ? 5'h10 : 5'h08;
      chk(fmt_o[2*k+:2] === f && drv_en_o[k] === (f != 2'h0), "format");
      chk(tail_ma_o[5*k+:5] === (d ? t : 5'h00), "tail current");
      chk(hcsl_load_o[2*k+:2] === (d ? n : 2'h0), "load select");
      chk(pos_pin_o[2*k+:2] === (f == 2'h3 ? m : 2'h0), "positive pin");
      chk(neg_pin_o[2*k+:2] === (f == 2'h3 ? n : 2'h0), "negative pin");
    end
  endtask

  task automatic t_div_rsv;
    logic [7:0] q; logic e;
    wr(8'h84, 8'h00);
    chk(div01_ratio_o === 9'h001, "ratio one");
    wr(8'h84, 8'hFF);
    chk(div01_ratio_o === 9'h100, "ratio 256");
    wb(1'b1, 8'h84, 8'h10, 4'h0, q, e);
    rd(8'h84, 8'hFF, 1'b0);
    wr(8'h7C, 8'hFF);
    rd(8'h7C, 8'hFE, 1'b0);
    wr(8'h80, 8'hFF);
    rd(8'h80, 8'h7E, 1'b0);
    rd(8'h94, 8'h00, 1'b1);
    rd(8'h7D, 8'h00, 1'b1);
  endtask

  // Reload from storage: reserved bits stay clear, flag set then cleared
  task automatic t_nv;
    @(posedge clk_i);
    {nv_channel_powerdown_i, nv_ctl0_i, nv_ctl1_i, nv_div01_i, nv_ctl2_i, nv_ctl3_i} <= {48{1'b1}};
    nv_load_i <= 1'b1;
    @(posedge clk_i);
    nv_load_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(adr_t[i], nv_t[i], 1'b0);
    rd(8'h90, 8'h01, 1'b0);
    wr(8'h90, 8'h01);
    rd(8'h90, 8'h00, 1'b0);
  endtask

  // ----------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------
  task automatic results;
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    results();
  end

  initial begin
    {clk_i, cyc_i, stb_i, we_i, nv_load_i, adr_i, dat_i, sel_i} = '0;
    {nv_channel_powerdown_i, nv_ctl0_i, nv_ctl1_i, nv_div01_i, nv_ctl2_i, nv_ctl3_i} = '0;
    err_total = 0;
    num_checks = 0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_channel_powerdown();
    t_fmt();
    t_div_rsv();
    t_nv();
    results();
  end
endmodule // occr_regs_tb
